// ===== verilog/icx_irq_ctrl.sv
// module: cpu interrupt controller top, enables, flags and forced call
`timescale 1ns/1ps

// Functional notes
// - ten request sources arbitrated over four priority levels
// - each source has its own request flag and its own enable bit
// - shared peripheral lines are ORed onto external sources four to six
// - a flag sets on its condition whether or not enabled
// - flags sampled each machine cycle, acknowledged on the next instruction
// - acknowledgement forces a long call to the source's fixed vector
// - only a strictly higher priority preempts a running service
// - return from interrupt ends the service at its level
// - least latency is one detect plus six long call machine cycles
// - global enable bit 7 low blocks every interrupt
// - primary register bits 4..0 enable serial0, timer1, ext1, timer0, ext0
// - external register bits 5..1 enable external interrupts 6..2
// - bit 6 of both registers is watchdog control, no masking effect
// - both enable registers reset to zero
// - a flag clears by hardware when its interrupt is taken
module icx_irq_ctrl #(
  parameter int GRP4_W = 2,
  parameter int GRP5_W = 3,
  parameter int GRP6_W = 3
) (
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire logic                          ce,
  // special function register port
  input  wire logic [7:0]                    sfrAddr,
  input  wire logic                          sfrWe,
  input  wire logic                          sfrRe,
  input  wire logic [7:0]                    sfrWdata,
  output logic      [7:0]                    sfrRdata,
  // request sources
  input  wire logic                          usrIrqHiN,
  input  wire logic                          usrIrqLoN,
  input  wire logic                          ext0EdgeMode,
  input  wire logic                          ext1EdgeMode,
  input  wire logic                          extPin2,
  input  wire logic                          extPin3,
  input  wire logic                          ext2Rising,
  input  wire logic                          ext3Rising,
  input  wire logic                          timer0Ovf,
  input  wire logic                          timer1Ovf,
  input  wire logic                          serial0Req,
  input  wire logic [GRP4_W-1:0]             smartCardIrq,
  input  wire logic [GRP5_W-1:0]             usbRtcKpIrq,
  input  wire logic [GRP6_W-1:0]             i2cFaultCmpIrq,
  input  wire logic [icx_pkg::NUM_SRC-1:0]   flagClr,
  input  wire logic [2*icx_pkg::NUM_SRC-1:0] srcPriority,
  // processor core handshake
  input  wire logic                          machCycle,
  input  wire logic                          instrBoundary,
  input  wire logic                          retiExec,
  output logic [icx_pkg::NUM_SRC-1:0]        reqFlags,
  output logic                               callActive,
  output logic                               callStart,
  output logic [15:0]                        callVector,
  output logic [3:0]                         callSource,
  output logic [3:0]                         inServiceMask,
  output logic                               wdCtlA,
  output logic                               wdCtlB
);
  import icx_pkg::*;

  // refuse a shared group with no request line behind it
  if (GRP4_W < 1 || GRP5_W < 1 || GRP6_W < 1) begin : g_bad_grp
    $error("icx_irq_ctrl: every shared group needs one line");
  end

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0]          ienPri;
    logic [7:0]          ienExt;
    logic [NUM_SRC-1:0]  flags;
    logic [NUM_SRC-1:0]  sampled;
    logic [3:0]          inService;
    icx_call_t           st;
    logic                active;             // forced call in progress
    logic [MC_CNT_W-1:0] mcCnt;
    logic [3:0]          src;
    logic [15:0]         vec;
    logic                start;
    logic [7:0]          rdata;
    logic [2:0]          grpPrev;
  } icx_state_t;

  icx_state_t cur_r;
  icx_state_t cur_nxt;

  // ==========================================================
  // source conditioning
  logic usrHiLvl;
  logic usrHiEdge;
  logic usrLoLvl;
  logic usrLoEdge;
  logic pin2Edge;
  logic pin3Edge;
  logic [2:0] grpNow;
  logic [NUM_SRC-1:0] setEvt;
  logic [NUM_SRC-1:0] enMask;
  logic [NUM_SRC-1:0] pollReq;
  logic grantValid;
  logic [3:0] grantSource;
  logic [1:0] grantLevel;

  // user i/o lines are active low pins
  icx_pin_sync u_syncHi (
    .clk         (clk),
    .srst        (srst),
    .ce          (ce),
    .pinIn       (usrIrqHiN),
    .activeHigh  (1'b0),
    .levelActive (usrHiLvl),
    .edgeActive  (usrHiEdge)
  );

  icx_pin_sync u_syncLo (
    .clk         (clk),
    .srst        (srst),
    .ce          (ce),
    .pinIn       (usrIrqLoN),
    .activeHigh  (1'b0),
    .levelActive (usrLoLvl),
    .edgeActive  (usrLoEdge)
  );

  // dedicated pins with selectable edge
  icx_pin_sync u_sync2 (
    .clk         (clk),
    .srst        (srst),
    .ce          (ce),
    .pinIn       (extPin2),
    .activeHigh  (ext2Rising),
    .levelActive (),
    .edgeActive  (pin2Edge)
  );

  icx_pin_sync u_sync3 (
    .clk         (clk),
    .srst        (srst),
    .ce          (ce),
    .pinIn       (extPin3),
    .activeHigh  (ext3Rising),
    .levelActive (),
    .edgeActive  (pin3Edge)
  );

  // shared peripheral lines ORed per source
  assign grpNow = {|i2cFaultCmpIrq, |usbRtcKpIrq, |smartCardIrq};

  // condition events, independent of any enable
  always_comb begin
    setEvt = '0;
    setEvt[SRC_EX0]  = ext0EdgeMode ? usrHiEdge : usrHiLvl;
    setEvt[SRC_EX1]  = ext1EdgeMode ? usrLoEdge : usrLoLvl;
    setEvt[SRC_T0]   = timer0Ovf;
    setEvt[SRC_T1]   = timer1Ovf;
    setEvt[SRC_SER0] = serial0Req;
    setEvt[SRC_EX2]  = pin2Edge;
    setEvt[SRC_EX3]  = pin3Edge;
    // shared groups count on the rising edge of the OR
    setEvt[SRC_EX6:SRC_EX4] = grpNow & ~cur_r.grpPrev;
  end

  // ==========================================================
  // enable decode; bit 6 of each register is left out on purpose
  always_comb begin
    enMask = '0;
    enMask[SRC_EX0]  = cur_r.ienPri[BIT_EX0];
    enMask[SRC_T0]   = cur_r.ienPri[BIT_T0];
    enMask[SRC_EX1]  = cur_r.ienPri[BIT_EX1];
    enMask[SRC_T1]   = cur_r.ienPri[BIT_T1];
    enMask[SRC_SER0] = cur_r.ienPri[BIT_SER0];
    enMask[SRC_EX6:SRC_EX2] = cur_r.ienExt[BIT_EX2 +: 5];
  end

  // polled requests: sampled flags under both masks
  assign pollReq = cur_r.ienPri[BIT_GLOBAL] ?
                   (cur_r.sampled & enMask) : '0;

  icx_prio_arb #(
    .NSRC (NUM_SRC)
  ) u_arb (
    .reqPending    (pollReq),
    .srcPriority   (srcPriority),
    .inServiceMask (cur_r.inService),
    .grantValid    (grantValid),
    .grantSource   (grantSource),
    .grantLevel    (grantLevel)
  );

  // ==========================================================
  // next state
  always_comb begin
    logic [NUM_SRC-1:0] takeMask;
    logic [3:0]         svc;
    logic               doTake;
    cur_nxt  = cur_r;
    takeMask = '0;
    svc      = cur_r.inService;
    doTake   = 1'b0;
    cur_nxt.start   = 1'b0;
    cur_nxt.grpPrev = grpNow;

    // register port: write then registered read
    if (sfrWe && sfrAddr == ADDR_IEN_PRI) begin
      cur_nxt.ienPri = sfrWdata & IEN_PRI_MASK;
    end else if (sfrWe && sfrAddr == ADDR_IEN_EXT) begin
      cur_nxt.ienExt = sfrWdata & IEN_EXT_MASK;
    end
    if (sfrRe && sfrAddr == ADDR_IEN_PRI) begin
      cur_nxt.rdata = cur_r.ienPri;
    end else if (sfrRe && sfrAddr == ADDR_IEN_EXT) begin
      cur_nxt.rdata = cur_r.ienExt;
    end else begin
      cur_nxt.rdata = RDATA_RST;
    end

    // return from interrupt retires the highest level in service
    if (retiExec) begin
      if (svc[3]) begin
        svc[3] = 1'b0;
      end else if (svc[2]) begin
        svc[2] = 1'b0;
      end else if (svc[1]) begin
        svc[1] = 1'b0;
      end else begin
        svc[0] = 1'b0;
      end
    end

    case (cur_r.st)
      CALL_IDLE: begin
        // poll at an instruction boundary on the machine cycle
        if (machCycle && instrBoundary && grantValid) begin
          doTake         = 1'b1;
          takeMask[grantSource] = 1'b1;
          svc[grantLevel] = 1'b1;
          cur_nxt.st     = CALL_RUN;
          cur_nxt.mcCnt  = '0;
          cur_nxt.src    = grantSource;
          cur_nxt.vec    = VEC_BASE
                           + 16'(grantSource) * VEC_STRIDE;
          cur_nxt.start  = 1'b1;
          cur_nxt.active = 1'b1;
        end
      end
      CALL_RUN: begin
        // long call occupies six machine cycles
        if (machCycle) begin
          if (cur_r.mcCnt == FORCED_LONG_CALL_LAST) begin
            cur_nxt.st = CALL_IDLE;
            cur_nxt.active = 1'b0;
          end else begin
            cur_nxt.mcCnt = cur_r.mcCnt + 1'b1;
          end
        end
      end
      default: begin
        cur_nxt.st = CALL_IDLE;
        cur_nxt.active = 1'b0;
      end
    endcase
    cur_nxt.inService = svc;

    // flags: new condition wins over hardware take and software clear
    cur_nxt.flags = (cur_r.flags & ~takeMask & ~flagClr)
                    | setEvt;
    // sample once per machine cycle; a taken source drops out
    if (machCycle) begin
      cur_nxt.sampled = cur_r.flags & ~takeMask;
    end else if (doTake) begin
      cur_nxt.sampled = cur_r.sampled & ~takeMask;
    end
  end

  // ==========================================================
  // state register, frozen while ce is low
  always_ff @(posedge clk) begin
    if (srst) begin
      cur_r         <= '0;
      cur_r.ienPri  <= IEN_RST;
      cur_r.ienExt  <= IEN_RST;
      cur_r.st      <= CALL_IDLE;
      cur_r.vec     <= VEC_BASE;
      cur_r.rdata   <= RDATA_RST;
    end else if (ce) begin
      cur_r <= cur_nxt;
    end
  end

  // ==========================================================
  // outputs straight from state
  assign sfrRdata      = cur_r.rdata;
  assign reqFlags      = cur_r.flags;
  assign callActive    = cur_r.active;
  assign callStart     = cur_r.start;
  assign callVector    = cur_r.vec;
  assign callSource    = cur_r.src;
  assign inServiceMask = cur_r.inService;
  assign wdCtlA        = cur_r.ienPri[BIT_WD_A];
  assign wdCtlB        = cur_r.ienExt[BIT_WD_B];

endmodule : icx_irq_ctrl

// ===== verilog/icx_pkg.sv
// package: constants and types for the cpu interrupt controller
package icx_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_SRC = 10;               // request sources
  localparam int NUM_LVL = 4;                // priority levels
  localparam int SRC_W   = 4;
  localparam int LVL_W   = 2;

  // ==========================================================
  // enable register map on the special function port
  localparam logic [7:0] ADDR_IEN_PRI = 8'ha8;
  localparam logic [7:0] ADDR_IEN_EXT = 8'hb8;
  localparam logic [7:0] IEN_RST      = 8'h00;
  localparam logic [7:0] IEN_PRI_MASK = 8'hdf; // bit 5 reserved
  localparam logic [7:0] IEN_EXT_MASK = 8'h7e; // bits 7 and 0 reserved
  localparam logic [7:0] RDATA_RST    = 8'h00;

  // field positions in the primary enable register
  localparam int BIT_GLOBAL = 7;
  localparam int BIT_WD_A   = 6;
  localparam int BIT_SER0   = 4;
  localparam int BIT_T1     = 3;
  localparam int BIT_EX1    = 2;
  localparam int BIT_T0     = 1;
  localparam int BIT_EX0    = 0;
  // field positions in the external enable register
  localparam int BIT_WD_B   = 6;
  localparam int BIT_EX2    = 1;             // ext 2..6 on bits 1..5

  // ==========================================================
  // source indices, also the fixed tie-break order (lowest wins)
  localparam int SRC_EX0  = 0;
  localparam int SRC_T0   = 1;
  localparam int SRC_EX1  = 2;
  localparam int SRC_T1   = 3;
  localparam int SRC_SER0 = 4;
  localparam int SRC_EX2  = 5;               // ext 2..6 on 5..9
  localparam int SRC_EX3  = 6;
  localparam int SRC_EX4  = 7;
  localparam int SRC_EX5  = 8;
  localparam int SRC_EX6  = 9;

  // ==========================================================
  // timing in machine cycles
  localparam int DETECT_MC  = 1;
  localparam int FORCED_LONG_CALL_MC   = 6;
  localparam int LATENCY_MC = DETECT_MC + FORCED_LONG_CALL_MC;
  localparam int MC_CNT_W   = 3;
  localparam logic [MC_CNT_W-1:0] FORCED_LONG_CALL_LAST = MC_CNT_W'(FORCED_LONG_CALL_MC - 1);

  // vector address = base + index * stride
  localparam logic [15:0] VEC_BASE   = 16'h0003;
  localparam logic [15:0] VEC_STRIDE = 16'h0008;

  // ==========================================================
  // types
  typedef enum logic {CALL_IDLE, CALL_RUN} icx_call_t;

endpackage : icx_pkg

// ===== verilog/icx_pin_sync.sv
// module: three-stage pin synchroniser with agreed level and edge pulse
`timescale 1ns/1ps

module icx_pin_sync (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic pinIn,
  input  wire logic activeHigh,
  output logic      levelActive,
  output logic      edgeActive
);
  import icx_pkg::*;

  typedef struct packed {
    logic [2:0] stage;                       // stage[0] feeds stage[1] only
    logic       stable;
  } icx_sync_t;

  icx_sync_t cur_r;
  icx_sync_t cur_nxt;

  // shift in; accept a change once stages two and three agree
  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.stage = {cur_r.stage[1:0], pinIn};
    if (cur_r.stage[1] == cur_r.stage[2]) begin
      cur_nxt.stable = cur_r.stage[2];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      // start at the inactive level so no false edge follows reset
      cur_r <= {{3{~activeHigh}}, ~activeHigh};
    end else if (ce) begin
      cur_r <= cur_nxt;
    end
  end

  // polarity applied after the filter
  assign levelActive = cur_r.stable ~^ activeHigh;
  assign edgeActive  = ce && (cur_nxt.stable != cur_r.stable)
                       && (cur_nxt.stable ~^ activeHigh);

endmodule : icx_pin_sync

// ===== verilog/icx_prio_arb.sv
// module: priority arbiter over the polled requests
`timescale 1ns/1ps

module icx_prio_arb #(
  parameter int NSRC = 10
) (
  input  wire logic [NSRC-1:0]         reqPending,
  input  wire logic [2*NSRC-1:0]       srcPriority,
  input  wire logic [3:0]              inServiceMask,
  output logic                         grantValid,
  output logic [3:0]                   grantSource,
  output logic [1:0]                   grantLevel
);
  import icx_pkg::*;

  // refuse source counts that the four-bit grant cannot name
  if (NSRC < 1 || NSRC > 16) begin : g_bad_nsrc
    $error("icx_prio_arb: NSRC must be 1..16");
  end

  // pick the highest level, then the lowest index at that level;
  // only levels strictly above every level in service qualify
  always_comb begin
    logic [2:0] floorLvl;
    logic [1:0] lv;
    floorLvl    = 3'h0;
    lv          = 2'h0;
    grantValid  = 1'b0;
    grantSource = 4'h0;
    grantLevel  = 2'h0;
    for (int l = 0; l < NUM_LVL; l++) begin
      if (inServiceMask[l]) begin
        floorLvl = 3'(l + 1);
      end
    end
    for (int l = NUM_LVL - 1; l >= 0; l--) begin
      lv = 2'(l);
      for (int s = NSRC - 1; s >= 0; s--) begin
        if (!grantValid && reqPending[s] && srcPriority[2*s +: 2] == lv
            && 3'(l) >= floorLvl) begin
          grantSource = 4'(s);
        end
      end
      if (!grantValid) begin
        for (int s = 0; s < NSRC; s++) begin
          if (reqPending[s] && srcPriority[2*s +: 2] == lv
              && 3'(l) >= floorLvl) begin
            grantValid = 1'b1;
            grantLevel = lv;
          end
        end
      end
    end
  end

endmodule : icx_prio_arb

// ===== sim/icx_irq_ctrl_props.sv
// checker: port properties of the cpu interrupt controller
`timescale 1ns/1ps

module icx_irq_ctrl_props (
  input wire logic                        clk,
  input wire logic                        srst,
  input wire logic                        ce,
  input wire logic [7:0]                  sfrAddr,
  input wire logic                        sfrWe,
  input wire logic                        sfrRe,
  input wire logic [7:0]                  sfrWdata,
  input wire logic [7:0]                  sfrRdata,
  input wire logic                        timer0Ovf,
  input wire logic [icx_pkg::NUM_SRC-1:0] flagClr,
  input wire logic                        machCycle,
  input wire logic [icx_pkg::NUM_SRC-1:0] reqFlags,
  input wire logic                        callActive,
  input wire logic                        callStart,
  input wire logic [15:0]                 callVector,
  input wire logic [3:0]                  callSource,
  input wire logic [3:0]                  inServiceMask,
  input wire logic                        wdCtlA
);
  import icx_pkg::*;
  logic       glbEn_r;
  logic [2:0] mcCnt_r;

  // ==========================================================
  // global enable shadow and long call machine cycle count
  always_ff @(posedge clk) begin
    if (srst) begin
      glbEn_r <= 1'b0;
      mcCnt_r <= 3'h0;
    end else if (ce) begin
      if (sfrWe && sfrAddr == ADDR_IEN_PRI) glbEn_r <= sfrWdata[7];
      if (callStart) mcCnt_r <= 3'(machCycle);
      else if (callActive && machCycle) mcCnt_r <= mcCnt_r + 3'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // ==========================================================
  // properties
  property p_vec;
    callStart |-> callVector == VEC_BASE + VEC_STRIDE * 16'(callSource);
  endproperty
  a_vec: assert property (p_vec) else $error("wrong vector");
  property p_six;
    $fell(callActive) |-> mcCnt_r == 3'h6;
  endproperty
  a_six: assert property (p_six) else $error("call too short");
  property p_under;
    callActive && !callStart |-> mcCnt_r < 3'h6;
  endproperty
  a_under: assert property (p_under) else $error("call too long");
  property p_rd_pri;
    ce && sfrRe && sfrAddr == ADDR_IEN_PRI |=> (sfrRdata & 8'h20) == 8'h00;
  endproperty
  a_rd_pri: assert property (p_rd_pri) else $error("bit5 set");
  property p_rd_ext;
    ce && sfrRe && sfrAddr == ADDR_IEN_EXT |=> (sfrRdata & 8'h81) == 8'h00;
  endproperty
  a_rd_ext: assert property (p_rd_ext) else $error("bit7/0 set");
  property p_wd;
    ce && sfrWe && sfrAddr == ADDR_IEN_PRI |=> wdCtlA == $past(sfrWdata[6]);
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog bit");
  property p_set;
    ce && timer0Ovf |=> reqFlags[SRC_T0];
  endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_clr;
    $fell(reqFlags[SRC_T0]) |->
      $past(flagClr[SRC_T0]) || (callStart && callSource == 4'h1);
  endproperty
  a_clr: assert property (p_clr) else $error("flag lost");
  property p_isr;
    callStart |-> inServiceMask > $past(inServiceMask);
  endproperty
  a_isr: assert property (p_isr) else $error("no preempt");
  property p_glb;
    callStart |-> $past(glbEn_r);
  endproperty
  a_glb: assert property (p_glb) else $error("global off");
endmodule : icx_irq_ctrl_props

// ===== sim/icx_core_model.sv
// partner: core timing model, machine cycles, boundaries and returns
`timescale 1ns/1ps

module icx_core_model #(
  parameter int MC_DIV = 3
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic retiReq,
  output logic      machCycle,
  output logic      instrBoundary,
  output logic      retiExec
);
  int divCnt;

  // strobe per machine cycle, boundary only on every other one
  always_ff @(posedge clk) begin
    if (srst) begin
      divCnt        <= 0;
      machCycle     <= 1'b0;
      instrBoundary <= 1'b0;
      retiExec      <= 1'b0;
    end else begin
      divCnt    <= (divCnt == MC_DIV - 1) ? 0 : divCnt + 1;
      machCycle <= (divCnt == MC_DIV - 1);
      retiExec  <= retiReq;
      if (machCycle) instrBoundary <= !instrBoundary;
    end
  end
endmodule : icx_core_model

// ===== sim/tb.sv
// testbench: directed scenarios for the cpu interrupt controller
`timescale 1ns/1ps

module tb;
  import icx_pkg::*;
  logic        clk, srst, ce, sfrWe, sfrRe, retiReq;
  logic [7:0]  sfrAddr, sfrWdata, sfrRdata;
  logic        usrIrqHiN, usrIrqLoN, ext0EdgeMode, ext1EdgeMode;
  logic        extPin2, extPin3, ext2Rising, ext3Rising;
  logic        timer0Ovf, timer1Ovf, serial0Req;
  logic [1:0]  smartCardIrq;
  logic [2:0]  usbRtcKpIrq, i2cFaultCmpIrq;
  logic [9:0]  flagClr, reqFlags;
  logic [19:0] srcPriority;
  logic        machCycle, instrBoundary, retiExec, callActive, callStart;
  logic        wdCtlA, wdCtlB;
  logic [15:0] callVector;
  logic [3:0]  callSource, inServiceMask;
  int          miscompares, checkCount, cycles;

  icx_irq_ctrl i_dut (
    .clk, .srst, .ce, .sfrAddr, .sfrWe, .sfrRe, .sfrWdata, .sfrRdata,
    .usrIrqHiN, .usrIrqLoN, .ext0EdgeMode, .ext1EdgeMode, .extPin2,
    .extPin3, .ext2Rising, .ext3Rising, .timer0Ovf, .timer1Ovf,
    .serial0Req, .smartCardIrq, .usbRtcKpIrq, .i2cFaultCmpIrq, .flagClr,
    .srcPriority, .machCycle, .instrBoundary, .retiExec, .reqFlags,
    .callActive, .callStart, .callVector, .callSource, .inServiceMask,
    .wdCtlA, .wdCtlB
  );
  icx_core_model i_core (
    .clk, .srst, .retiReq, .machCycle, .instrBoundary, .retiExec
  );

  // ==========================================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfrAddr = a;
    sfrWdata = d;
    sfrWe = 1'b1;
    tick(1);
    sfrWe = 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfrAddr = a;
    sfrRe = 1'b1;
    tick(1);
    sfrRe = 1'b0;
    chk(16'(sfrRdata), 16'(e));
    tick(1);
  endtask : rd
  task automatic clrFlags();
    flagClr = '1;
    tick(1);
    flagClr = '0;
    chk(16'(reqFlags), 16'h0000);
  endtask : clrFlags
  task automatic return_from_interrupt();
    retiReq = 1'b1;
    tick(1);
    retiReq = 1'b0;
    tick(2);
  endtask : return_from_interrupt
  // wait for a forced call, judge it and let it finish
  task automatic waitCall(input int src);
    int n;
    n = 0;
    while (callStart !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    chk(16'(callSource), 16'(src));
    chk(callVector, 16'h0003 + 16'(8 * src));
    chk(16'(reqFlags[src]), 16'h0000);
    while (callActive === 1'b1 && n < 120) begin
      tick(1);
      n++;
    end
    chk(16'(callActive), 16'h0000);
  endtask : waitCall

  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk(callVector, 16'h0003);
    rd(ADDR_IEN_PRI, 8'h00);
    rd(ADDR_IEN_EXT, 8'h00);
    tick(4);
    clrFlags();
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs();
    wr(ADDR_IEN_PRI, 8'hff);
    rd(ADDR_IEN_PRI, 8'hdf);
    chk(16'(wdCtlA), 16'h0001);
    wr(ADDR_IEN_EXT, 8'hff);
    rd(ADDR_IEN_EXT, 8'h7e);
    chk(16'(wdCtlB), 16'h0001);
    rd(8'h87, 8'h00);
    wr(ADDR_IEN_PRI, 8'h00);
    wr(ADDR_IEN_EXT, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_flags();
    {timer0Ovf, timer1Ovf, serial0Req} = 3'h7;
    {smartCardIrq, usbRtcKpIrq, i2cFaultCmpIrq} = 8'ha1;
    {extPin2, extPin3, usrIrqHiN, usrIrqLoN} = 4'h8;
    tick(1);
    {timer0Ovf, timer1Ovf, serial0Req} = 3'h0;
    {smartCardIrq, usbRtcKpIrq, i2cFaultCmpIrq} = 8'h00;
    tick(6);
    chk(16'(reqFlags), 16'h03ff);
    chk(16'(callActive), 16'h0000);
    {extPin2, extPin3, usrIrqHiN, usrIrqLoN} = 4'h7;
    tick(6);
    clrFlags();
    $display("test flags done");
  endtask : t_flags
  task automatic t_global();
    wr(ADDR_IEN_PRI, 8'h02);
    timer0Ovf = 1'b1;
    tick(1);
    timer0Ovf = 1'b0;
    tick(30);
    chk(16'(callActive), 16'h0000);
    wr(ADDR_IEN_PRI, 8'h82);
    waitCall(SRC_T0);
    return_from_interrupt();
    chk(16'(inServiceMask), 16'h0000);
    $display("test global done");
  endtask : t_global
  task automatic t_prio();
    srcPriority = 20'h00244;
    wr(ADDR_IEN_PRI, 8'h9a);
    {timer0Ovf, timer1Ovf} = 2'h3;
    tick(1);
    {timer0Ovf, timer1Ovf} = 2'h0;
    waitCall(SRC_T0);
    tick(30);
    chk(16'(callActive), 16'h0000);
    serial0Req = 1'b1;
    tick(1);
    serial0Req = 1'b0;
    waitCall(SRC_SER0);
    chk(16'(inServiceMask), 16'h0006);
    return_from_interrupt();
    tick(30);
    chk(16'(inServiceMask), 16'h0002);
    return_from_interrupt();
    waitCall(SRC_T1);
    return_from_interrupt();
    wr(ADDR_IEN_PRI, 8'h80);
    srcPriority = '0;
    $display("test prio done");
  endtask : t_prio
  task automatic t_ext();
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_IEN_EXT, 8'h08 << i);
      {i2cFaultCmpIrq[0], usbRtcKpIrq[0], smartCardIrq[0]} = 3'h1 << i;
      tick(1);
      {i2cFaultCmpIrq[0], usbRtcKpIrq[0], smartCardIrq[0]} = 3'h0;
      waitCall(SRC_EX4 + i);
      return_from_interrupt();
    end
    $display("test ext done");
  endtask : t_ext
  task automatic summarize();
    $display("checks %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // ==========================================================
  // main sequence
  initial begin
    {ce, srst} = 2'b11;
    {sfrWe, sfrRe, retiReq, timer0Ovf, timer1Ovf, serial0Req} = '0;
    sfrAddr = 8'h00;
    sfrWdata = 8'h00;
    {usrIrqHiN, usrIrqLoN, ext0EdgeMode, extPin3, ext2Rising} = 5'h1f;
    {ext1EdgeMode, extPin2, ext3Rising} = 3'h0;
    {smartCardIrq, usbRtcKpIrq, i2cFaultCmpIrq} = '0;
    flagClr = '0;
    srcPriority = '0;
    tick(16);
    srst = 1'b0;
    t_reset();
    t_regs();
    t_flags();
    t_global();
    t_prio();
    t_ext();
    summarize();
  end
endmodule : tb

bind icx_irq_ctrl icx_irq_ctrl_props u_props (
  .clk, .srst, .ce, .sfrAddr, .sfrWe, .sfrRe, .sfrWdata, .sfrRdata,
  .timer0Ovf, .flagClr, .machCycle, .reqFlags, .callActive, .callStart,
  .callVector, .callSource, .inServiceMask, .wdCtlA
);
